// ==== src/i2cp_slave.sv ====
// Device end: two-wire slave giving access to paged 8-bit registers.
`timescale 1ns/10ps
`default_nettype none
`include "i2cp_regs.svh"
module i2cp_slave
	import i2cp_pkg::*;
#(
	parameter int PAGE_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	i2cp_if.slave                  bus,
	input  wire logic              addr_strap_hi_i,
	input  wire logic              addr_strap_lo_i,
	output logic [PAGE_W-1:0]      page_o,
	output logic [6:0]             reg_addr_o,
	output logic                   reg_wr_o,
	output logic [7:0]             reg_wdata_o,
	input  wire logic [7:0]        reg_rdata_i
);
	// ============================================================
	// Parameter check
	if (PAGE_W < 6 || PAGE_W > 8) begin : g_chk
		$error("PAGE_W must lie between 6 and 8");
	end

	// ============================================================
	// State
	typedef struct packed {
		logic [1:0]    scl_sy;
		logic [1:0]    sda_sy;
		logic [1:0]    hi_sy;
		logic [1:0]    lo_sy;
		logic          scl_q;
		logic          sda_q;
		i2cp_sst_type  st;
		i2cp_byte_type kind;
		logic [3:0]    cnt;
		logic [7:0]    sh;
		logic          rd;
		logic          oe;
		logic [6:0]    ptr;
		logic [PAGE_W-1:0] page;
		logic          wr;
		logic [7:0]    wdata;
	} i2cp_slv_type;

	i2cp_slv_type r;
	i2cp_slv_type next_r;

	logic       scl;
	logic       sda;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;
	logic [6:0] own_addr;
	logic [7:0] rd_byte;

	// ============================================================
	// Line conditioning
	always_comb begin
		scl        = r.scl_sy[1];
		sda        = r.sda_sy[1];
		scl_rise   = scl && !r.scl_q;
		scl_fall   = !scl && r.scl_q;
		start_seen = scl && r.scl_q && r.sda_q && !sda;
		stop_seen  = scl && r.scl_q && !r.sda_q && sda;
		own_addr   = {`I2CP_ADDR_HI, r.hi_sy[1], r.lo_sy[1]};
		// The page register reads back from the port itself.
		if (r.ptr == `I2CP_PAGE_REG) begin
			rd_byte = 8'(r.page);
		end else begin
			rd_byte = reg_rdata_i;
		end
	end

	// ============================================================
	// Protocol engine
	always_comb begin
		next_r        = r;
		next_r.scl_sy = {r.scl_sy[0], bus.scl};
		next_r.sda_sy = {r.sda_sy[0], bus.sda};
		next_r.hi_sy  = {r.hi_sy[0], addr_strap_hi_i};
		next_r.lo_sy  = {r.lo_sy[0], addr_strap_lo_i};
		next_r.scl_q  = scl;
		next_r.sda_q  = sda;
		next_r.wr     = 1'b0;
		// The pointer moves one cycle after the write strobe, so that the strobe
		// still carries the address of the register that it writes.
		if (r.wr) begin
			next_r.ptr = r.ptr + 7'h01;
		end
		if (start_seen) begin
			// Accepted in any state, so a repeated start restarts decoding.
			next_r.st   = S_RECV;
			next_r.kind = P_ADDR;
			next_r.cnt  = 4'h0;
			next_r.oe   = 1'b0;
		end else if (stop_seen) begin
			next_r.st = S_IDLE;
			next_r.oe = 1'b0;
		end else begin
			case (r.st)
				S_IDLE: begin
					next_r.oe = 1'b0;
				end
				S_RECV: begin
					if (scl_rise) begin
						// Bits arrive most significant first.
						next_r.sh  = {r.sh[6:0], sda};
						next_r.cnt = r.cnt + 4'h1;
					end else if (scl_fall && r.cnt == 4'h8) begin
						next_r.st = S_RACK;
						next_r.oe = 1'b1;
						case (r.kind)
							P_ADDR: begin
								next_r.rd = r.sh[0];
								if (r.sh == `I2CP_GCALL) begin
									next_r.kind = P_PTR;
								end else if (r.sh[7:1] == own_addr) begin
									next_r.kind = P_PTR;
								end else begin
									// Not ours: stay off the line.
									next_r.st = S_IDLE;
									next_r.oe = 1'b0;
								end
							end
							P_PTR: begin
								next_r.ptr  = r.sh[6:0];
								next_r.kind = P_DATA;
							end
							default: begin
								next_r.wr    = 1'b1;
								next_r.wdata = r.sh;
								if (r.ptr == `I2CP_PAGE_REG) begin
									next_r.page = r.sh[PAGE_W-1:0];
								end
							end
						endcase
					end
				end
				S_RACK: begin
					if (scl_fall) begin
						next_r.cnt = 4'h0;
						if (r.rd && r.kind == P_PTR) begin
							// Reads start from the pointer left by an earlier write.
							next_r.st = S_SEND;
							next_r.sh = rd_byte;
							next_r.oe = !rd_byte[7];
						end else begin
							next_r.st = S_RECV;
							next_r.oe = 1'b0;
						end
					end
				end
				S_SEND: begin
					if (scl_fall) begin
						// Data moves only after the clock has gone low.
						if (r.cnt == 4'h7) begin
							next_r.st = S_SACK;
							next_r.oe = 1'b0;
						end else begin
							next_r.cnt = r.cnt + 4'h1;
							next_r.sh  = {r.sh[6:0], 1'b0};
							next_r.oe  = !r.sh[6];
						end
					end
				end
				S_SACK: begin
					if (scl_rise) begin
						if (sda) begin
							// Master declined: wait for stop or start.
							next_r.st = S_IDLE;
						end else begin
							next_r.ptr = r.ptr + 7'h01;
						end
					end else if (scl_fall) begin
						next_r.st  = S_SEND;
						next_r.cnt = 4'h0;
						next_r.sh  = rd_byte;
						next_r.oe  = !rd_byte[7];
					end
				end
				default: begin
					next_r.st = S_IDLE;
					next_r.oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			r <= '0;
			r.scl_sy <= 2'h3;
			r.sda_sy <= 2'h3;
			r.scl_q  <= 1'b1;
			r.sda_q  <= 1'b1;
			r.st     <= S_IDLE;
			r.kind   <= P_ADDR;
		end else begin
			r <= next_r;
		end
	end

	// ============================================================
	// Outputs
	// The clock line is never touched; data is only ever sunk.
	assign bus.s_sda_o  = 1'b0;
	assign bus.s_sda_oe = r.oe;
	assign page_o       = r.page;
	assign reg_addr_o   = r.ptr;
	assign reg_wr_o     = r.wr;
	assign reg_wdata_o  = r.wdata;
endmodule // i2cp_slave
`default_nettype wire

// ==== src/i2cp_regs.svh ====
// Constants of the paged two-wire register port and its bus controller.
// Notes on behaviour
// - Works at 100 kHz and 400 kHz.
// - Address is 00110 plus two strap bits.
// - Device is slave only, never drives clock.
// - Lines only pulled low, released for high.
// - Data changes at clock low, sampled high.
// - Data edge during clock high: start/stop.
// - Master starts from idle; stop returns idle.
// - Address byte: seven address bits, direction.
// - Device acknowledges own byte on ninth clock.
// - Reader releases data; master always clocks.
// - Master acknowledges read bytes to continue.
// - High data at acknowledge means no acknowledge.
// - Repeated start restarts address decoding.
// - General call address 00h is acknowledged.
// - Write bytes go to incrementing registers.
// - Acknowledged read continues with next register.
// - Registers eight bits, most significant first.
// - Host uses only pages 0,1,4,5,32-47.
// - Writing register 0 selects the page.
`ifndef I2CP_REGS_SVH
`define I2CP_REGS_SVH
// ============================================================
// Bus addressing
`define I2CP_ADDR_HI   5'h06
`define I2CP_GCALL     8'h00
`define I2CP_PAGE_REG  7'h00
// ============================================================
// Controller register offsets and fields
`define I2CP_CMD_OFS    8'h00
`define I2CP_STAT_OFS   8'h04
`define I2CP_CFG_OFS    8'h08
`define I2CP_CMD_OP     1:0
`define I2CP_CMD_NACK   2
`define I2CP_CMD_TX     15:8
`define I2CP_STAT_BUSY  0
`define I2CP_STAT_NACK  1
`define I2CP_STAT_RX    15:8
`define I2CP_CFG_FAST   0
// ============================================================
// Timing: the bit period is cut into four quarters.
`define I2CP_CLK_KHZ   100000
`define I2CP_STD_KHZ   100
`define I2CP_FAST_KHZ  400
`define I2CP_QTR(k)    ((`I2CP_CLK_KHZ + 4 * (k) - 1) / (4 * (k)))
`endif

// ==== src/i2cp_pkg.sv ====
// Types shared by both ends of the paged register port.
package i2cp_pkg;
	typedef enum logic [2:0] {S_IDLE, S_RECV, S_RACK, S_SEND, S_SACK} i2cp_sst_type;
	typedef enum logic [1:0] {P_ADDR, P_PTR, P_DATA} i2cp_byte_type;
	typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} i2cp_op_type;
endpackage

// ==== src/i2cp_if.sv ====
// Two-wire bus between controller and device, with open-drain resolution.
`timescale 1ns/10ps
`default_nettype none
interface i2cp_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;
	// A line is low whenever any party sinks it, high otherwise.
	assign scl = !(m_scl_oe && !m_scl_o);
	assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
	modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
		input sda);
	modport slave (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// ==== src/i2cp_master.sv ====
// Host end: APB-programmed two-wire bus controller working byte by byte.
`timescale 1ns/10ps
`default_nettype none
`include "i2cp_regs.svh"
module i2cp_master
	import i2cp_pkg::*;
#(
	parameter int QTR_STD  = `I2CP_QTR(`I2CP_STD_KHZ),
	parameter int QTR_FAST = `I2CP_QTR(`I2CP_FAST_KHZ)
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	i2cp_if.master           bus,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o
);
	// ============================================================
	// Parameter check
	if (QTR_STD < 2 || QTR_STD > 255 || QTR_FAST < 2 || QTR_FAST > 255) begin : g_chk
		$error("quarter-bit counts must lie between 2 and 255");
	end

	localparam logic [7:0] QS = 8'(QTR_STD - 1);
	localparam logic [7:0] QF = 8'(QTR_FAST - 1);

	// ============================================================
	// State
	typedef struct packed {
		logic [1:0]  sda_sy;
		logic        busy;
		i2cp_op_type op;
		logic [1:0]  ph;
		logic [7:0]  cnt;
		logic [3:0]  bits;
		logic [8:0]  sh;
		logic        samp;
		logic        scl_oe;
		logic        sda_oe;
		logic        nack;
		logic [7:0]  rx;
		logic        fast;
		logic [31:0] rdata;
		logic        err;
	} i2cp_mst_type;

	i2cp_mst_type r;
	i2cp_mst_type next_r;

	logic       setup;
	logic       wr_acc;
	logic       mapped;
	logic [7:0] qtr;

	always_comb begin
		setup  = psel_i && !penable_i;
		wr_acc = psel_i && penable_i && pwrite_i;
		mapped = paddr_i == `I2CP_CMD_OFS || paddr_i == `I2CP_STAT_OFS ||
			paddr_i == `I2CP_CFG_OFS;
		qtr    = r.fast ? QF : QS;
	end

	// ============================================================
	// Register access and bit engine
	always_comb begin
		next_r        = r;
		next_r.sda_sy = {r.sda_sy[0], bus.sda};
		if (setup) begin
			next_r.err   = !mapped;
			next_r.rdata = 32'h0;
			if (paddr_i == `I2CP_STAT_OFS) begin
				next_r.rdata[`I2CP_STAT_BUSY] = r.busy;
				next_r.rdata[`I2CP_STAT_NACK] = r.nack;
				next_r.rdata[`I2CP_STAT_RX]   = r.rx;
			end else if (paddr_i == `I2CP_CFG_OFS) begin
				next_r.rdata[`I2CP_CFG_FAST] = r.fast;
			end
		end
		if (wr_acc && paddr_i == `I2CP_CFG_OFS) begin
			next_r.fast = pwdata_i[`I2CP_CFG_FAST];
		end
		if (wr_acc && paddr_i == `I2CP_CMD_OFS && !r.busy) begin
			// Commands written while busy are dropped.
			next_r.busy = 1'b1;
			next_r.op   = i2cp_op_type'(pwdata_i[`I2CP_CMD_OP]);
			next_r.ph   = 2'h0;
			next_r.cnt  = qtr;
			next_r.bits = 4'h0;
			next_r.scl_oe = 1'b1;
			if (i2cp_op_type'(pwdata_i[`I2CP_CMD_OP]) == OP_READ) begin
				// Release for the slave's bits, then answer.
				next_r.sh = {8'hff, pwdata_i[`I2CP_CMD_NACK]};
			end else begin
				next_r.sh = {pwdata_i[`I2CP_CMD_TX], 1'b1};
			end
		end else if (r.busy) begin
			if (r.cnt != 8'h0) begin
				next_r.cnt = r.cnt - 8'h01;
			end else begin
				next_r.cnt = qtr;
				next_r.ph  = r.ph + 2'h1;
				case (r.op)
					OP_START: begin
						// Clock high, then data falls: start or repeated start.
						case (r.ph)
							2'h0: next_r.sda_oe = 1'b0;
							2'h1: next_r.scl_oe = 1'b0;
							2'h2: next_r.sda_oe = 1'b1;
							default: next_r.busy = 1'b0;
						endcase
					end
					OP_STOP: begin
						case (r.ph)
							2'h0: next_r.sda_oe = 1'b1;
							2'h1: next_r.scl_oe = 1'b0;
							2'h2: next_r.sda_oe = 1'b0;
							default: next_r.busy = 1'b0;
						endcase
					end
					default: begin
						// Data changes a quarter after the clock falls.
						case (r.ph)
							2'h0: next_r.sda_oe = !r.sh[8];
							2'h1: next_r.scl_oe = 1'b0;
							2'h2: next_r.samp   = r.sda_sy[1];
							default: begin
								next_r.sh     = {r.sh[7:0], r.samp};
								next_r.bits   = r.bits + 4'h1;
								next_r.scl_oe = 1'b1;
								next_r.ph     = 2'h0;
								if (r.bits == 4'h8) begin
									next_r.busy = 1'b0;
									next_r.rx   = r.sh[7:0];
									next_r.nack = r.samp;
								end
							end
						endcase
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			r <= '0;
			r.sda_sy <= 2'h3;
			r.op     <= OP_START;
		end else begin
			r <= next_r;
		end
	end

	// ============================================================
	// Outputs
	assign bus.m_scl_o  = 1'b0;
	assign bus.m_sda_o  = 1'b0;
	assign bus.m_scl_oe = r.scl_oe;
	assign bus.m_sda_oe = r.sda_oe;
	assign prdata_o     = r.rdata;
	assign pready_o     = 1'b1;
	assign pslverr_o    = psel_i && penable_i && r.err;
endmodule // i2cp_master
`default_nettype wire

// ==== tb/i2cp_props.sv ====
// Bus-level checks on the two-wire link between both ends.
`timescale 1ns/10ps
`default_nettype none
module i2cp_props (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic m_scl_o,
	input wire logic m_scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// ====
	// Only start and stop may move the data line while the clock is high.
	sequence start_c;
		$fell(sda) && scl && $past(scl);
	endsequence
	sequence stop_c;
		$rose(sda) && scl && $past(scl);
	endsequence
	a_sink_only: assert property (!(m_scl_oe && m_scl_o) && !(m_sda_oe && m_sda_o)
		&& !(s_sda_oe && s_sda_o)) else $error("line driven high");
	a_start_hold: assert property (start_c |-> (scl && !sda)[*4])
		else $error("start not held");
	a_stop_idle: assert property (stop_c |=> (!s_sda_oe && !m_sda_oe)[*8])
		else $error("bus not idle after stop");
	a_slave_stable: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
		else $error("slave moved data with clock high");
	a_ack_hold: assert property ($rose(scl) && s_sda_oe |-> s_sda_oe[*4])
		else $error("slave bit not held");
	a_no_clash: assert property (s_sda_oe && scl |-> !m_sda_oe)
		else $error("both ends drive data");
	a_scl_high: assert property ($rose(scl) |-> scl[*4])
		else $error("clock high too short");
	a_scl_low: assert property ($fell(scl) |-> !scl[*4] ##[1:16] scl)
		else $error("clock low out of range");
endmodule // i2cp_props
`default_nettype wire

// ==== tb/i2c_slave_paged_register_port_tb_top.sv ====
// Bench joining controller and device, checked against a byte model.
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_paged_register_port_tb_top import i2cp_pkg::*;;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic hi = 1'b0;
	logic lo = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] page;
	logic [6:0] radr;
	logic wr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] regf [0:32767];
	logic [7:0] mem [int];
	logic [7:0] rnd = 8'h5d;
	int err_count = 0;
	int tests_run = 0;
	int mptr = 0;
	int mpage = 0;
	int cyc = 0;
	i2cp_if bus_if ();
	i2cp_master #(.QTR_STD(4), .QTR_FAST(2)) i2cp_master_inst (.clk_i(clk_i),
		.reset_i(reset_i), .bus(bus_if), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr));
	i2cp_slave i2cp_slave_inst (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if),
		.addr_strap_hi_i(hi), .addr_strap_lo_i(lo), .page_o(page), .reg_addr_o(radr),
		.reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
	i2cp_props i2cp_props_inst (.clk_i(clk_i), .reset_i(reset_i),
		.m_scl_o(bus_if.m_scl_o), .m_scl_oe(bus_if.m_scl_oe), .m_sda_o(bus_if.m_sda_o),
		.m_sda_oe(bus_if.m_sda_oe), .s_sda_o(bus_if.s_sda_o), .s_sda_oe(bus_if.s_sda_oe),
		.scl(bus_if.scl), .sda(bus_if.sda));
	// ====
	// Register file behind the device, indexed by page and pointer.
	assign rdata = regf[{page, radr}];
	always @(posedge clk_i) begin
		if (wr) regf[{page, radr}] <= wdata;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			end_sim;
		end
	end
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// ====
	// The request is held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cmd(input logic [1:0] op, input logic [7:0] tx, input logic nk,
		output logic [31:0] st);
		logic e;
		apb(1'b1, 8'h00, {16'h0, tx, 5'h0, nk, op}, st, e);
		do apb(1'b0, 8'h04, 32'h0, st, e); while (st[0] !== 1'b0);
	endtask
	task automatic ev(input logic [1:0] op);
		logic [31:0] st;
		cmd(op, 8'h00, 1'b0, st);
	endtask
	task automatic bw(input logic [7:0] b, input logic nk);
		logic [31:0] st;
		cmd(OP_WRITE, b, 1'b0, st);
		chk(st[1], nk);
	endtask
	task automatic br(input logic l);
		logic [31:0] st;
		cmd(OP_READ, 8'h00, l, st);
		chk(st[15:8], mem[mpage * 128 + mptr]);
		mptr = (mptr + 1) % 128;
	endtask
	task automatic wt(input logic [7:0] ab, input logic [7:0] p, input logic [7:0] f,
		input int n);
		logic [7:0] d;
		ev(OP_START);
		bw(ab, 1'b0);
		bw(p, 1'b0);
		mptr = p;
		d = f;
		repeat (n) begin
			bw(d, 1'b0);
			if (mptr == 0) mpage = d;
			mem[mpage * 128 + mptr] = d;
			mptr = (mptr + 1) % 128;
			rnd = nxt(rnd);
			d = rnd;
		end
		ev(OP_STOP);
		chk(page, mpage[7:0]);
	endtask
	task automatic rt(input logic [7:0] ab, input logic [7:0] p, input int n);
		ev(OP_START);
		bw(ab, 1'b0);
		bw(p, 1'b0);
		mptr = p;
		ev(OP_START);
		bw(ab | 8'h01, 1'b0);
		for (int i = 1; i <= n; i++) br(i == n);
		ev(OP_STOP);
	endtask
	// ====
	initial begin
		logic [31:0] r;
		logic e;
		logic [7:0] pl [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h20, 8'h2f};
		for (int i = 0; i < 32768; i++) regf[i] = 8'h00;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		apb(1'b0, 8'h04, 32'h0, r, e);
		chk(r, 32'h0);
		apb(1'b0, 8'h0c, 32'h0, r, e);
		chk({e, r}, {1'b1, 32'h0});
		chk(page, 8'h00);
		$display("reset test done");
		for (int s = 0; s < 4; s++) begin
			{hi, lo} <= s[1:0];
			for (int a = 0; a < 4; a++) begin
				ev(OP_START);
				bw({5'h06, a[1:0], 1'b0}, a != s);
				ev(OP_STOP);
			end
		end
		$display("address test done");
		wt(8'h00, 8'h06, rnd, 2);
		rt(8'h36, 8'h06, 2);
		$display("general call test done");
		// Half of the pages run at the fast rate to cover both bus speeds.
		foreach (pl[i]) begin
			if (i == 3) begin
				apb(1'b1, 8'h08, 32'h1, r, e);
				apb(1'b0, 8'h08, 32'h0, r, e);
				chk(r, 32'h1);
			end
			wt(8'h36, 8'h00, pl[i], 4);
			rt(8'h36, 8'h00, 4);
		end
		$display("page test done");
		end_sim;
	end
endmodule // i2c_slave_paged_register_port_tb_top
`default_nettype wire
